// [bench/sensor_result_and_irq_control_regs_test.sv]
// Purpose: self-checking bench of the result and irq register bank
// Assumes: host model issues requests, bench drives measurement strobes
// Notes: inputs change on falling edges only
`timescale 1ns/1ps
`default_nettype none
module sensor_result_and_irq_control_regs_test;
    logic i_core_clk = 1'b0;
    logic i_srst = 1'b1;
    srirq_pkg::srirq_meas_t als = '0;
    srirq_pkg::srirq_meas_t prox = '0;
    srirq_pkg::srirq_req_t req;
    logic [7:0] rdata;
    logic int_n;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;

    // 50 MHz clock
    always #10 i_core_clk = ~i_core_clk;

    srirq_regs dut (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_als(als),
        .i_prox(prox), .i_req(req), .o_reg_rdata(rdata), .o_int_n(int_n));
    srirq_host host (.i_core_clk(i_core_clk), .o_req(req), .i_rdata(rdata));

    // verdict and end of run
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // hang guard, well above the expected run length
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            conclude();
        end
    end

    // byte compare
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    // register read and compare
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        host.rd(a, v);
        chk($sformatf("reg %h", a), e, v);
    endtask

    // interrupt pin compare
    task automatic pin(input logic e);
        chk("int pin", {7'h00, e}, {7'h00, int_n});
    endtask

    // one measurement strobe on the chosen engine
    task automatic meas(input logic is_als, input logic [15:0] v);
        @(negedge i_core_clk);
        if (is_als) als = '{1'b1, v};
        else prox = '{1'b1, v};
        @(negedge i_core_clk);
        als.valid = 1'b0;
        prox.valid = 1'b0;
    endtask

    // every mapped byte and one unmapped byte read zero after reset
    task automatic t_reset();
        for (int a = 8'h85; a <= 8'h8e; a++) rchk(8'(a), 8'h00);
        rchk(8'h90, 8'h00);
        pin(1'b1);
        $display("reset test done");
    endtask

    // result byte map and read-only result bytes
    task automatic t_results();
        meas(1'b1, 16'h1234);
        meas(1'b0, 16'habcd);
        for (int a = 8'h85; a <= 8'h88; a++) host.wr(8'(a), 8'hff);
        rchk(8'h85, 8'h12);
        rchk(8'h86, 8'h34);
        rchk(8'h87, 8'hab);
        rchk(8'h88, 8'hcd);
        $display("results test done");
    endtask

    // control bits read back, bit 4 reads zero
    task automatic t_ctrl();
        host.wr(8'h89, 8'hff);
        rchk(8'h89, 8'hef);
        host.wr(8'h89, 8'h00);
        rchk(8'h89, 8'h00);
        $display("control test done");
    endtask

    // ready flags gated by enables, sticky until written one
    task automatic t_ready();
        meas(1'b0, 16'h0001);
        meas(1'b1, 16'h0001);
        rchk(8'h8e, 8'h00);
        pin(1'b1);
        host.wr(8'h89, 8'h0c);
        meas(1'b0, 16'h0002);
        rchk(8'h8e, 8'h08);
        pin(1'b0);
        meas(1'b1, 16'h0002);
        rchk(8'h8e, 8'h0c);
        host.wr(8'h8e, 8'h08);
        rchk(8'h8e, 8'h04);
        pin(1'b0);
        host.wr(8'h8e, 8'h04);
        host.wr(8'h89, 8'h00);
        rchk(8'h8e, 8'h00);
        pin(1'b1);
        $display("ready test done");
    endtask

    // thresholds, source select, run length and run reset
    task automatic t_thresh();
        host.wr(8'h8a, 8'ha5);
        host.wr(8'h8d, 8'h5a);
        rchk(8'h8a, 8'ha5);
        rchk(8'h8d, 8'h5a);
        host.wr(8'h8a, 8'h00);
        host.wr(8'h8b, 8'h10);
        host.wr(8'h8c, 8'h01);
        host.wr(8'h8d, 8'h00);
        rchk(8'h8b, 8'h10);
        rchk(8'h8c, 8'h01);
        host.wr(8'h89, 8'h22);
        meas(1'b0, 16'h0200);
        meas(1'b0, 16'h0050);
        meas(1'b0, 16'h0200);
        rchk(8'h8e, 8'h00);
        meas(1'b0, 16'h0200);
        rchk(8'h8e, 8'h01);
        pin(1'b0);
        host.wr(8'h8e, 8'h01);
        host.wr(8'h89, 8'h23);
        meas(1'b0, 16'h0200);
        meas(1'b0, 16'h0200);
        rchk(8'h8e, 8'h00);
        meas(1'b1, 16'h0005);
        meas(1'b1, 16'h0005);
        rchk(8'h8e, 8'h02);
        host.wr(8'h8e, 8'h02);
        host.wr(8'h89, 8'he2);
        for (int i = 0; i < 127; i++) meas(1'b0, 16'h0200);
        rchk(8'h8e, 8'h00);
        meas(1'b0, 16'h0200);
        rchk(8'h8e, 8'h01);
        host.wr(8'h8e, 8'h01);
        $display("threshold test done");
    endtask

    // low byte read after high byte belongs to the same result
    task automatic t_coherent();
        meas(1'b1, 16'h5566);
        rchk(8'h85, 8'h55);
        meas(1'b1, 16'h7788);
        rchk(8'h86, 8'h66);
        rchk(8'h85, 8'h77);
        rchk(8'h86, 8'h88);
        $display("coherence test done");
    endtask

    // reset for five cycles, then the scenarios
    initial begin
        repeat (5) @(posedge i_core_clk);
        @(negedge i_core_clk);
        i_srst = 1'b0;
        t_reset();
        t_results();
        t_ctrl();
        t_ready();
        t_thresh();
        t_coherent();
        conclude();
    end
endmodule
`default_nettype wire

// [bench/srirq_host.sv]
// Purpose: host bus master model driving the byte register port
// Assumes: strobes launch on falling edges, taken on the next rising edge
// Notes: released address and data show the inverse, never stale values
`timescale 1ns/1ps
`default_nettype none
module srirq_host (
    input wire logic i_core_clk,
    output var srirq_pkg::srirq_req_t o_req,
    input wire logic [7:0] i_rdata
);
    // bus idle from time zero
    initial o_req = '{1'b0, 1'b0, 8'h00, 8'h00};

    // one-cycle write strobe, then release with inverted fields
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_core_clk);
        o_req = '{1'b0, 1'b1, a, d};
        @(negedge i_core_clk);
        o_req = '{1'b0, 1'b0, ~a, ~d};
    endtask

    // read strobe; data sampled on the falling edge after the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_core_clk);
        o_req = '{1'b1, 1'b0, a, 8'h00};
        @(negedge i_core_clk);
        d = i_rdata;
        o_req = '{1'b0, 1'b0, ~a, 8'hff};
    endtask
endmodule
`default_nettype wire

// [hw/srirq_pkg.sv]
// Purpose: shared constants and types of the sensor result and irq bank
// Assumes: byte-wide register port fed by the two-wire bus engine
// Notes: offsets are byte addresses on the two-wire bus
package srirq_pkg;
    // register offsets
    localparam logic [7:0] ADDR_ALS_HI = 8'h85;
    localparam logic [7:0] ADDR_ALS_LO = 8'h86;
    localparam logic [7:0] ADDR_PROX_HI = 8'h87;
    localparam logic [7:0] ADDR_PROX_LO = 8'h88;
    localparam logic [7:0] ADDR_IRQ_CTRL = 8'h89;
    localparam logic [7:0] ADDR_LOW_HI = 8'h8a;
    localparam logic [7:0] ADDR_LOW_LO = 8'h8b;
    localparam logic [7:0] ADDR_HIGH_HI = 8'h8c;
    localparam logic [7:0] ADDR_HIGH_LO = 8'h8d;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h8e;
    // interrupt control field positions
    localparam int CTRL_CNT_LSB = 5;
    localparam int CTRL_PROX_EN = 3;
    localparam int CTRL_ALS_EN = 2;
    localparam int CTRL_THR_EN = 1;
    localparam int CTRL_THR_SEL = 0;
    // interrupt status field positions
    localparam int STAT_PROX_RDY = 3;
    localparam int STAT_ALS_RDY = 2;
    localparam int STAT_BELOW = 1;
    localparam int STAT_ABOVE = 0;
    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [3:0] STAT_RESET = 4'h0;
    localparam logic [15:0] THRESH_RESET = 16'h0000;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    // one new measurement from an engine
    typedef struct packed {
        logic valid;
        logic [15:0] value;
    } srirq_meas_t;
    // byte register request from the bus engine
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } srirq_req_t;
    // run counter states
    typedef enum logic [1:0] {
        RUN_INSIDE = 2'b01,
        RUN_BEYOND = 2'b10
    } srirq_run_t;
endpackage

// [hw/srirq_regs.sv]
// Purpose: result, threshold and interrupt registers of the light sensor
// Assumes: two-wire bus engine gives byte read and write strobes
// Notes: read data appears the cycle after the read strobe
//
// What this block does
// - ambient result high byte at 85h, low byte at 86h.
// - ambient result bytes are read-only; writes leave the value intact.
// - proximity result read-only, high byte 87h, low byte 88h.
// - count field bits 7:5 at 89h needs two-to-the-value runs; resets 000.
// - bit 2 enables interrupt on each new ambient result.
// - bit 1 enables interrupt on high or low threshold exceedance.
// - bit 0 selects threshold source: 0 proximity, 1 ambient.
// - status flags stick until host writes one; interrupt low while any set.
// - low threshold at 8Ah/8Bh, high threshold at 8Ch/8Dh, read/write.
`timescale 1ns/1ps
`default_nettype none
module srirq_regs (
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire srirq_pkg::srirq_meas_t i_als,
    input wire srirq_pkg::srirq_meas_t i_prox,
    input wire srirq_pkg::srirq_req_t i_req,
    output logic [7:0] o_reg_rdata,
    output logic o_int_n
);
    logic [15:0] als_q, prox_q;
    logic [15:0] low_q, high_q;
    logic [7:0] ctrl_q;
    logic [3:0] stat_q, stat_d;
    logic [7:0] als_shadow_q, prox_shadow_q;
    logic als_hold_q, prox_hold_q;
    logic [7:0] rdata_q;
    logic dir_above_q;
    wire logic [3:0] stat_set, stat_clr;
    wire logic wr_ctrl, wr_stat;
    wire logic wr_low_hi, wr_low_lo, wr_high_hi, wr_high_lo;
    wire logic rd_als_hi, rd_prox_hi;
    wire logic rd_als_lo, rd_prox_lo;
    wire logic als_snap, prox_snap;
    wire logic sample;
    wire logic [15:0] sample_val;
    wire logic is_above, is_below;
    wire logic run_hit;
    wire logic [7:0] rd_mux;

    // write and read decode
    assign wr_ctrl = i_req.wr && i_req.addr == srirq_pkg::ADDR_IRQ_CTRL;
    assign wr_stat = i_req.wr && i_req.addr == srirq_pkg::ADDR_IRQ_STAT;
    assign wr_low_hi = i_req.wr && i_req.addr == srirq_pkg::ADDR_LOW_HI;
    assign wr_low_lo = i_req.wr && i_req.addr == srirq_pkg::ADDR_LOW_LO;
    assign wr_high_hi = i_req.wr && i_req.addr == srirq_pkg::ADDR_HIGH_HI;
    assign wr_high_lo = i_req.wr && i_req.addr == srirq_pkg::ADDR_HIGH_LO;
    assign rd_als_hi = i_req.rd && i_req.addr == srirq_pkg::ADDR_ALS_HI;
    assign rd_prox_hi = i_req.rd && i_req.addr == srirq_pkg::ADDR_PROX_HI;
    assign rd_als_lo = i_req.rd && i_req.addr == srirq_pkg::ADDR_ALS_LO;
    assign rd_prox_lo = i_req.rd && i_req.addr == srirq_pkg::ADDR_PROX_LO;

    // shadow loads on a high read, or freely while no pair is open
    assign als_snap = rd_als_hi || !als_hold_q;
    assign prox_snap = rd_prox_hi || !prox_hold_q;

    // threshold source select and comparison
    assign sample = ctrl_q[srirq_pkg::CTRL_THR_SEL] ? i_als.valid
                                                    : i_prox.valid;
    assign sample_val = ctrl_q[srirq_pkg::CTRL_THR_SEL] ? i_als.value
                                                        : i_prox.value;
    assign is_above = sample_val > high_q;
    assign is_below = sample_val < low_q;

    // run of consecutive out-of-range samples
    srirq_run_counter u_run (
        .i_core_clk(i_core_clk),
        .i_srst(i_srst),
        .i_sample(sample),
        .i_beyond(is_above || is_below),
        .i_count_exp(ctrl_q[7:srirq_pkg::CTRL_CNT_LSB]),
        .o_hit(run_hit)
    );

    // status set and clear terms, set wins over clear
    assign stat_set[srirq_pkg::STAT_PROX_RDY] =
        i_prox.valid && ctrl_q[srirq_pkg::CTRL_PROX_EN];
    assign stat_set[srirq_pkg::STAT_ALS_RDY] =
        i_als.valid && ctrl_q[srirq_pkg::CTRL_ALS_EN];
    assign stat_set[srirq_pkg::STAT_BELOW] =
        run_hit && !dir_above_q && ctrl_q[srirq_pkg::CTRL_THR_EN];
    assign stat_set[srirq_pkg::STAT_ABOVE] =
        run_hit && dir_above_q && ctrl_q[srirq_pkg::CTRL_THR_EN];
    assign stat_clr = wr_stat ? i_req.wdata[3:0] : 4'h0;
    assign stat_d = (stat_q & ~stat_clr) | stat_set;

    // read mux, unmapped offsets read zero
    assign rd_mux =
        i_req.addr == srirq_pkg::ADDR_ALS_HI ? als_q[15:8] :
        i_req.addr == srirq_pkg::ADDR_ALS_LO ? als_shadow_q :
        i_req.addr == srirq_pkg::ADDR_PROX_HI ? prox_q[15:8] :
        i_req.addr == srirq_pkg::ADDR_PROX_LO ? prox_shadow_q :
        i_req.addr == srirq_pkg::ADDR_IRQ_CTRL ? ctrl_q :
        i_req.addr == srirq_pkg::ADDR_LOW_HI ? low_q[15:8] :
        i_req.addr == srirq_pkg::ADDR_LOW_LO ? low_q[7:0] :
        i_req.addr == srirq_pkg::ADDR_HIGH_HI ? high_q[15:8] :
        i_req.addr == srirq_pkg::ADDR_HIGH_LO ? high_q[7:0] :
        i_req.addr == srirq_pkg::ADDR_IRQ_STAT ? {4'h0, stat_q} : 8'h00;

    // results stored whole; no bus write path reaches them
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            als_q <= srirq_pkg::RESULT_RESET;
            prox_q <= srirq_pkg::RESULT_RESET;
        end else begin
            if (i_als.valid) als_q <= i_als.value;
            if (i_prox.valid) prox_q <= i_prox.value;
        end
    end

    // low byte frozen from a high-byte read until the low-byte read
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            als_shadow_q <= 8'h00;
            prox_shadow_q <= 8'h00;
            als_hold_q <= 1'b0;
            prox_hold_q <= 1'b0;
        end else begin
            if (als_snap) als_shadow_q <= als_q[7:0];
            if (prox_snap) prox_shadow_q <= prox_q[7:0];
            if (rd_als_hi) als_hold_q <= 1'b1;
            else if (rd_als_lo) als_hold_q <= 1'b0;
            if (rd_prox_hi) prox_hold_q <= 1'b1;
            else if (rd_prox_lo) prox_hold_q <= 1'b0;
        end
    end

    // control and threshold registers
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            ctrl_q <= srirq_pkg::CTRL_RESET;
            low_q <= srirq_pkg::THRESH_RESET;
            high_q <= srirq_pkg::THRESH_RESET;
        end else begin
            if (wr_ctrl) ctrl_q <= {i_req.wdata[7:5], 1'b0, i_req.wdata[3:0]};
            if (wr_low_hi) low_q[15:8] <= i_req.wdata;
            if (wr_low_lo) low_q[7:0] <= i_req.wdata;
            if (wr_high_hi) high_q[15:8] <= i_req.wdata;
            if (wr_high_lo) high_q[7:0] <= i_req.wdata;
        end
    end

    // status flags, read data and exceedance direction
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            stat_q <= srirq_pkg::STAT_RESET;
            rdata_q <= 8'h00;
            dir_above_q <= 1'b0;
        end else begin
            stat_q <= stat_d;
            if (i_req.rd) rdata_q <= rd_mux;
            if (sample) dir_above_q <= is_above;
        end
    end

    assign o_reg_rdata = rdata_q;
    assign o_int_n = ~|stat_q;

    a_als_result_ro: assert property (@(posedge i_core_clk)
        disable iff (i_srst)
        i_req.wr && !i_als.valid |=> als_q == $past(als_q))
        else $error("ambient result changed by write");
    a_als_high_read: assert property (@(posedge i_core_clk)
        disable iff (i_srst)
        rd_als_hi |=> o_reg_rdata == $past(als_q[15:8]))
        else $error("ambient high byte read wrong");
    a_prox_capture: assert property (@(posedge i_core_clk)
        disable iff (i_srst)
        i_prox.valid |=> prox_q == $past(i_prox.value))
        else $error("proximity result not stored");
    a_prox_ready_flag: assert property (@(posedge i_core_clk)
        disable iff (i_srst)
        i_prox.valid && ctrl_q[3] |=> stat_q[3] && !o_int_n)
        else $error("proximity ready flag not set");
    a_als_ready_flag: assert property (@(posedge i_core_clk)
        disable iff (i_srst)
        i_als.valid && ctrl_q[2] |=> stat_q[2])
        else $error("ambient ready flag not set");
    a_thr_gate_off: assert property (@(posedge i_core_clk)
        disable iff (i_srst)
        !ctrl_q[1] && stat_q[1:0] == 2'b00 |=> stat_q[1:0] == 2'b00)
        else $error("threshold flag set while disabled");
    a_flag_sticks: assert property (@(posedge i_core_clk)
        disable iff (i_srst)
        stat_q[0] && !(wr_stat && i_req.wdata[0]) |=> stat_q[0] && !o_int_n)
        else $error("threshold flag dropped without clear");
    a_set_wins: assert property (@(posedge i_core_clk)
        disable iff (i_srst)
        i_als.valid && ctrl_q[2] && wr_stat && i_req.wdata[2] |=> stat_q[2])
        else $error("clear beat a same-cycle set");
    a_low_thresh_rw: assert property (@(posedge i_core_clk)
        disable iff (i_srst)
        wr_low_hi |=> low_q[15:8] == $past(i_req.wdata))
        else $error("low threshold high byte not kept");
    a_als_coherent: assert property (@(posedge i_core_clk)
        disable iff (i_srst)
        rd_als_hi |=> als_shadow_q == $past(als_q[7:0]))
        else $error("ambient low byte not snapshot");
    a_als_low_held: assert property (@(posedge i_core_clk)
        disable iff (i_srst)
        als_hold_q && !rd_als_hi |=> als_shadow_q == $past(als_shadow_q))
        else $error("ambient low byte moved while held");
    a_prox_coherent: assert property (@(posedge i_core_clk)
        disable iff (i_srst)
        rd_prox_hi |=> prox_shadow_q == $past(prox_q[7:0]))
        else $error("proximity low byte not snapshot");
    a_count_field_rw: assert property (@(posedge i_core_clk)
        disable iff (i_srst)
        wr_ctrl |=> ctrl_q[7:5] == $past(i_req.wdata[7:5]))
        else $error("count field not written");
    a_status_clear: assert property (@(posedge i_core_clk)
        disable iff (i_srst)
        wr_stat && i_req.wdata[3] && !stat_set[3] |=> !stat_q[3])
        else $error("proximity ready flag not cleared");
    a_high_thresh_rw: assert property (@(posedge i_core_clk)
        disable iff (i_srst)
        wr_high_lo |=> high_q[7:0] == $past(i_req.wdata))
        else $error("high threshold low byte not kept");
    a_above_flag: assert property (@(posedge i_core_clk)
        disable iff (i_srst)
        run_hit && dir_above_q && ctrl_q[1] |=> stat_q[0] && !o_int_n)
        else $error("above limit flag not set");
endmodule
`default_nettype wire

// [hw/srirq_run_counter.sv]
// Purpose: counts an unbroken run of out-of-range samples
// Assumes: i_sample is a one-cycle strobe per compared measurement
// Notes: o_hit pulses one cycle after the sample that completes the run
`timescale 1ns/1ps
`default_nettype none
module srirq_run_counter (
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_sample,
    input wire logic i_beyond,
    input wire logic [2:0] i_count_exp,
    output logic o_hit
);
    srirq_pkg::srirq_run_t state_q, state_d;
    logic [7:0] cnt_q, cnt_d;
    logic hit_q, hit_d;
    wire logic [7:0] cnt_inc;
    wire logic [7:0] target;

    // run length needed is two to the field value
    function automatic logic [7:0] pow2(input logic [2:0] e);
        pow2 = 8'h01 << e;
    endfunction

    assign cnt_inc = cnt_q + 8'h01;
    assign target = pow2(i_count_exp);

    // next state of the run
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        hit_d = 1'b0;
        case (state_q)
            srirq_pkg::RUN_INSIDE,
            srirq_pkg::RUN_BEYOND: begin
                if (i_sample && !i_beyond) begin
                    cnt_d = 8'h00;
                    state_d = srirq_pkg::RUN_INSIDE;
                end else if (i_sample && cnt_inc >= target) begin
                    hit_d = 1'b1;
                    cnt_d = 8'h00;
                    state_d = srirq_pkg::RUN_INSIDE;
                end else if (i_sample) begin
                    cnt_d = cnt_inc;
                    state_d = srirq_pkg::RUN_BEYOND;
                end
            end
            default: begin
                cnt_d = 8'h00;
                state_d = srirq_pkg::RUN_INSIDE;
            end
        endcase
    end

    // run registers
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            state_q <= srirq_pkg::RUN_INSIDE;
            cnt_q <= 8'h00;
            hit_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            hit_q <= hit_d;
        end
    end

    assign o_hit = hit_q;

    a_run_single_hit: assert property (@(posedge i_core_clk)
        disable iff (i_srst)
        i_sample && i_beyond && i_count_exp == 3'h0 |=> o_hit)
        else $error("one-count run did not hit");
    a_run_inside_reset: assert property (@(posedge i_core_clk)
        disable iff (i_srst)
        i_sample && !i_beyond |=> cnt_q == 8'h00 && !o_hit)
        else $error("run not cleared by in-range sample");
    a_run_no_early: assert property (@(posedge i_core_clk)
        disable iff (i_srst)
        o_hit |-> $past(cnt_q) == $past(target) - 8'h01)
        else $error("hit before full run");
endmodule
`default_nettype wire
